// ==== bench/fpm_datapath_bench.sv ====
// self-checking bench for the multiply and move datapath
`timescale 1ns/1ns
`include "fpm_defines.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module fpm_datapath_bench;
  localparam [63:0] ONE = 64'h3ff0_0000_0000_0000;
  localparam [63:0] TWO = 64'h4000_0000_0000_0000;
  localparam [63:0] THR = 64'h4008_0000_0000_0000;
  localparam [63:0] INF = 64'h7ff0_0000_0000_0000;
  localparam [63:0] QN  = 64'h7ff8_0000_0000_0000;
  localparam [63:0] ZRO = 64'h0000_0000_0000_0000;
  localparam [63:0] FIN = 64'h3ff0_0000_1000_0000;
  reg         i_clk;
  reg         i_rst;
  reg         issue;
  reg  [2:0]  op;
  reg         sgl;
  reg         rec;
  reg  [63:0] opa;
  reg  [63:0] opb;
  reg  [63:0] opc;
  reg         ld;
  reg  [31:0] ld_val;
  wire [31:0] st_in;
  wire        done;
  wire [63:0] res;
  wire        res_we;
  wire [31:0] st;
  wire        st_we;
  wire [3:0]  cond;
  wire        cond_we;
  integer     n_mismatch;
  integer     checks_done;
  integer     m;

  fpm_datapath u_fpm_datapath (
    .i_clk(i_clk), .i_rst(i_rst), .i_issue(issue), .i_op(op), .i_single(sgl),
    .i_record_bit(rec), .i_operand_a_reg(opa), .i_operand_b_reg(opb),
    .i_operand_c_reg(opc), .i_float_status_control(st_in), .o_done(done),
    .o_dest_float_reg(res), .o_dest_we(res_we), .o_float_status_control(st),
    .o_status_we(st_we), .o_cond_field_one(cond), .o_cond_we(cond_we));
  fpm_regfile_model u_fpm_regfile_model (
    .i_clk(i_clk), .i_rst(i_rst), .i_load(ld), .i_load_val(ld_val),
    .i_status_we(st_we), .i_status(st), .o_status(st_in));

  // ********************************
  // tasks
  // ********************************
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task set_status(input [31:0] v);
    begin
      @(negedge i_clk);
      ld = 1'b1;
      ld_val = v;
      @(negedge i_clk);
      ld = 1'b0;
    end
  endtask
  // leading idle edge lets the model capture the previous write-back
  task run(input [2:0] o, input s, input r, input [63:0] a, input [63:0] b, input [63:0] c);
    integer k;
    begin
      @(negedge i_clk);
      op = o;
      sgl = s;
      rec = r;
      opa = a;
      opb = b;
      opc = c;
      issue = 1'b1;
      @(negedge i_clk);
      issue = 1'b0;
      k = 0;
      while (done !== 1'b1 && k < 4) begin
        @(negedge i_clk);
        k++;
      end
      if (k == 4) begin
        n_mismatch++;
        tally_and_finish;
      end
    end
  endtask

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  // ********************************
  // sequence
  // ********************************
  initial begin
    {i_rst, issue, sgl, rec, ld} = 5'h10;
    {op, opa, opb, opc, ld_val} = 0;
    n_mismatch = 0;
    checks_done = 0;
    repeat (20) @(negedge i_clk);
    i_rst = 1'b0;
    set_status(32'h9000_0000);
    run(`FPM_OP_MOVE, 1'b0, 1'b1, ZRO, 64'h7ff4_0000_0000_0001, ZRO);
    `CHK(res, 64'h7ff4_0000_0000_0001)
    `CHK(st_we, 1'b0)
    `CHK(cond, 4'h9)
    `CHK(cond_we, 1'b1)
    run(`FPM_OP_NEG, 1'b0, 1'b0, ZRO, ONE, ZRO);
    `CHK(res, 64'hbff0_0000_0000_0000)
    run(`FPM_OP_NABS, 1'b0, 1'b0, ZRO, ONE, ZRO);
    `CHK(res, 64'hbff0_0000_0000_0000)
    set_status(32'h0000_0000);
    run(`FPM_OP_MUL, 1'b0, 1'b0, TWO, ZRO, THR);
    `CHK(res, 64'h4018_0000_0000_0000)
    `CHK(st[16:12], `FPM_C_PNORM)
    run(`FPM_OP_MSUB, 1'b0, 1'b0, TWO, ONE, THR);
    `CHK(res, 64'h4014_0000_0000_0000)
    run(`FPM_OP_NMADD, 1'b0, 1'b0, TWO, ONE, THR);
    `CHK(res, 64'hc01c_0000_0000_0000)
    run(`FPM_OP_MUL, 1'b0, 1'b0, 64'h0000_0000_0000_0001, ZRO, 64'h43b0_0000_0000_0000);
    `CHK(res, 64'h0090_0000_0000_0000)
    for (m = 0; m < 4; m++) begin
      set_status({30'h0000_0000, m[1:0]});
      run(`FPM_OP_MUL, 1'b1, 1'b0, FIN, ZRO, ONE);
      `CHK(res, (m == 2) ? 64'h3ff0_0000_2000_0000 : ONE)
      `CHK(st[`FPM_B_FRND], (m == 2))
      `CHK(st[`FPM_B_FINX], 1'b1)
      run(`FPM_OP_MUL, 1'b0, 1'b0, FIN, ZRO, ONE);
      `CHK(res, FIN)
    end
    set_status(32'h0000_0002);
    run(`FPM_OP_NMADD, 1'b1, 1'b0, FIN, ZRO, ONE);
    `CHK(res, 64'hbff0_0000_2000_0000)
    set_status(32'h0000_0000);
    run(`FPM_OP_MUL, 1'b0, 1'b1, 64'h7e70_0000_0000_0000, ZRO, 64'h7e70_0000_0000_0000);
    `CHK(res, INF)
    `CHK(cond, 4'h9)
    set_status(32'h0000_0000);
    run(`FPM_OP_NMADD, 1'b0, 1'b1, INF, ONE, ZRO);
    `CHK(res, QN)
    `CHK(st[`FPM_B_IMZ], 1'b1)
    `CHK(st[16:12], `FPM_C_QNAN)
    `CHK(cond, 4'ha)
    run(`FPM_OP_NMADD, 1'b0, 1'b0, 64'hfff8_0000_0000_0000, ONE, ONE);
    `CHK(res, 64'hfff8_0000_0000_0000)
    set_status(32'h0000_0000);
    run(`FPM_OP_NMADD, 1'b0, 1'b0, 64'hfff4_0000_0000_0000, ONE, ONE);
    `CHK(res, 64'hfffc_0000_0000_0000)
    `CHK(st[`FPM_B_SNAN], 1'b1)
    run(`FPM_OP_MSUB, 1'b0, 1'b0, INF, INF, ONE);
    `CHK(res, QN)
    `CHK(st[`FPM_B_ISI], 1'b1)
    set_status(32'h0000_0000);
    run(`FPM_OP_MUL, 1'b0, 1'b0, INF, ZRO, ZRO);
    `CHK(st[`FPM_B_ISI], 1'b0)
    `CHK(st[`FPM_B_IMZ], 1'b1)
    set_status(32'h0000_4080);
    run(`FPM_OP_MUL, 1'b0, 1'b1, INF, ZRO, ZRO);
    `CHK(res_we, 1'b0)
    `CHK(st[16:12], `FPM_C_PNORM)
    `CHK(cond, 4'he)
    tally_and_finish;
  end
endmodule // fpm_datapath_bench

// ==== bench/fpm_regfile_model.sv ====
// status word holder standing in for issue logic and register file
`timescale 1ns/1ns
module fpm_regfile_model (
  input  wire        i_clk,
  input  wire        i_rst,
  input  wire        i_load,
  input  wire [31:0] i_load_val,
  input  wire        i_status_we,
  input  wire [31:0] i_status,
  output wire [31:0] o_status
);
  reg [31:0] status_q;
  // datapath keeps no status, so write-back lands here for the next issue
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst)
      status_q <= 32'h0000_0000;
    else if (i_load)
      status_q <= i_load_val;
    else if (i_status_we)
      status_q <= i_status;
  end
  assign o_status = status_q;
endmodule // fpm_regfile_model

// ==== bench/fpm_sva.sv ====
// concurrent checks on the ports of the multiply and move datapath
`timescale 1ns/1ns
`include "fpm_defines.vh"
module fpm_sva (
  input wire        i_clk,
  input wire        i_rst,
  input wire        i_issue,
  input wire [2:0]  i_op,
  input wire        i_single,
  input wire        i_record_bit,
  input wire [63:0] i_operand_a_reg,
  input wire [63:0] i_operand_b_reg,
  input wire [63:0] i_operand_c_reg,
  input wire [31:0] i_float_status_control,
  input wire        o_done,
  input wire [63:0] o_dest_float_reg,
  input wire        o_dest_we,
  input wire [31:0] o_float_status_control,
  input wire        o_status_we,
  input wire [3:0]  o_cond_field_one,
  input wire        o_cond_we
);
  // ********************************
  // properties
  // ********************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_done_follows: assert property (o_done |-> $past(i_issue))
    else $error("done without a preceding issue");
  a_done_answer: assert property (i_issue |-> ##1 o_done)
    else $error("done missing one cycle after issue");
  a_move_copy: assert property (
    i_issue && i_op == `FPM_OP_MOVE |=>
    o_dest_we && o_dest_float_reg == $past(i_operand_b_reg))
    else $error("move result differs from source");
  a_nabs_sign: assert property (
    i_issue && i_op == `FPM_OP_NABS |=>
    o_dest_float_reg == {1'b1, $past(i_operand_b_reg[62:0])})
    else $error("negative absolute value wrong");
  a_neg_sign: assert property (
    i_issue && i_op == `FPM_OP_NEG |=>
    o_dest_float_reg == {~$past(i_operand_b_reg[63]), $past(i_operand_b_reg[62:0])})
    else $error("negate result wrong");
  a_cond_move: assert property (
    i_issue && i_record_bit && i_op < 3'h3 |=>
    o_cond_we && o_cond_field_one == $past(i_float_status_control[31:28]))
    else $error("condition field not copied from status");
  a_cond_quiet: assert property (i_issue && !i_record_bit |=> !o_cond_we)
    else $error("condition field written without record bit");
  a_status_kept: assert property (i_issue && i_op < 3'h3 |=> !o_status_we)
    else $error("move type operation wrote status");
  a_status_upd: assert property (
    i_issue && i_op > 3'h2 && i_op < 3'h6 |=>
    o_status_we ##1 (!o_status_we || $past(i_issue)))
    else $error("arithmetic status write not a single pulse");
  a_trap_class: assert property (
    o_status_we && !o_dest_we |->
    o_float_status_control[29] &&
    o_float_status_control[16:12] == $past(i_float_status_control[16:12]))
    else $error("trapped invalid altered class or missed summary");
  a_mul_no_isi: assert property (
    i_issue && i_op == `FPM_OP_MUL && !i_float_status_control[23] |=>
    !o_float_status_control[23])
    else $error("multiply raised infinity minus infinity");
endmodule // fpm_sva

bind fpm_datapath fpm_sva u_fpm_sva (
  .i_clk                  (i_clk),
  .i_rst                  (i_rst),
  .i_issue                (i_issue),
  .i_op                   (i_op),
  .i_single               (i_single),
  .i_record_bit           (i_record_bit),
  .i_operand_a_reg        (i_operand_a_reg),
  .i_operand_b_reg        (i_operand_b_reg),
  .i_operand_c_reg        (i_operand_c_reg),
  .i_float_status_control (i_float_status_control),
  .o_done                 (o_done),
  .o_dest_float_reg       (o_dest_float_reg),
  .o_dest_we              (o_dest_we),
  .o_float_status_control (o_float_status_control),
  .o_status_we            (o_status_we),
  .o_cond_field_one       (o_cond_field_one),
  .o_cond_we              (o_cond_we)
);

// ==== hdl/fpm_datapath.v ====
// floating-point move, negate and multiply / fused multiply execution datapath
`timescale 1ns/1ns
`include "fpm_defines.vh"
module fpm_datapath (
  input  wire        i_clk,
  input  wire        i_rst,
  input  wire        i_issue,
  input  wire [2:0]  i_op,
  input  wire        i_single,
  input  wire        i_record_bit,
  input  wire [63:0] i_operand_a_reg,
  input  wire [63:0] i_operand_b_reg,
  input  wire [63:0] i_operand_c_reg,
  input  wire [31:0] i_float_status_control,
  output reg         o_done,
  output reg  [63:0] o_dest_float_reg,
  output reg         o_dest_we,
  output reg  [31:0] o_float_status_control,
  output reg         o_status_we,
  output reg  [3:0]  o_cond_field_one,
  output reg         o_cond_we
);
  // ********************************
  // result class lookup
  // ********************************
  function [4:0] class_of;
    input [63:0] v;
    input        den;
    begin
      if (v[62:52] == 11'h7ff && v[51:0] != 52'h0)
        class_of = `FPM_C_QNAN;
      else if (v[62:52] == 11'h7ff)
        class_of = v[63] ? `FPM_C_NINF : `FPM_C_PINF;
      else if (v[62:0] == 63'h0)
        class_of = v[63] ? `FPM_C_NZERO : `FPM_C_PZERO;
      else if (den || v[62:52] == 11'h000)
        class_of = v[63] ? `FPM_C_NDEN : `FPM_C_PDEN;
      else
        class_of = v[63] ? `FPM_C_NNORM : `FPM_C_PNORM;
    end
  endfunction

  // ********************************
  // operand unpack
  // ********************************
  wire [191:0] opnd;
  wire [2:0]   sgn;
  wire [41:0]  exps;
  wire [158:0] sigs;
  wire [2:0]   zro;
  wire [2:0]   inf;
  wire [2:0]   nan;
  wire [2:0]   snan;

  assign opnd = {i_operand_c_reg, i_operand_b_reg, i_operand_a_reg};

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_unp
      fpm_unpack u_unp (
        .i_val  (opnd[g*64 +: 64]),
        .o_sign (sgn[g]),
        .o_exp  (exps[g*14 +: 14]),
        .o_sig  (sigs[g*53 +: 53]),
        .o_zero (zro[g]),
        .o_inf  (inf[g]),
        .o_nan  (nan[g]),
        .o_snan (snan[g])
      );
    end
  endgenerate

  wire signed [13:0] ea = exps[13:0];
  wire signed [13:0] eb = exps[27:14];
  wire signed [13:0] ec = exps[41:28];
  wire        [1:0]  rmode = i_float_status_control[`FPM_RMODE_HI:`FPM_RMODE_LO];

  // ********************************
  // product and aligned addend
  // ********************************
  reg                is_arith;
  reg                has_b;
  reg                neg;
  reg                sp;
  reg                sbe;
  reg                far;
  reg signed [13:0]  pe;
  reg signed [13:0]  d;
  reg signed [13:0]  r;
  reg signed [13:0]  e0;
  reg        [105:0] prod;
  reg        [168:0] p_acc;
  reg        [168:0] b_ext;
  reg        [168:0] b_acc;
  reg        [168:0] mag;
  reg                msgn;
  reg                zsgn;

  always @* begin
    is_arith = (i_op == `FPM_OP_MUL) || (i_op == `FPM_OP_MSUB) || (i_op == `FPM_OP_NMADD);
    has_b = (i_op == `FPM_OP_MSUB) || (i_op == `FPM_OP_NMADD);
    neg   = (i_op == `FPM_OP_NMADD);
    sp    = sgn[0] ^ sgn[2];
    sbe   = sgn[1] ^ (i_op == `FPM_OP_MSUB);
    pe    = ea + ec;
    prod  = sigs[52:0] * sigs[158:106];
    d     = eb - pe;
    // addend far above the product: product shrinks to a sticky bit
    far   = has_b && (d > `FPM_FAR_ADD);
    p_acc = far ? {168'h0, |prod} : {61'h0, prod, 2'h0};
    b_ext = {1'b0, (has_b ? sigs[105:53] : 53'h0), 115'h0};
    r     = far ? 14'sh0000 : (`FPM_FAR_ADD - d);
    if (r > 14'sh00a8) begin
      b_acc = {168'h0, |b_ext};
    end else begin
      b_acc = b_ext >> r[7:0];
      b_acc[0] = b_acc[0] | (((b_ext >> r[7:0]) << r[7:0]) != b_ext);
    end
    e0 = far ? (eb - 14'sh00a7) : (pe - 14'sh006a);
    if (!has_b || sp == sbe) begin
      mag  = p_acc + b_acc;
      msgn = sp;
    end else if (p_acc >= b_acc) begin
      mag  = p_acc - b_acc;
      msgn = sp;
    end else begin
      mag  = b_acc - p_acc;
      msgn = sbe;
    end
    // exact zero sum of unlike signs takes its sign from the rounding mode
    zsgn = (!has_b || sp == sbe) ? sp : (rmode == `FPM_RM_MINF);
    if (mag == 169'h0)
      msgn = zsgn;
  end

  wire [63:0] r_res;
  wire        r_frnd;
  wire        r_finx;
  wire        r_ovf;
  wire        r_unf;
  wire        r_den;

  fpm_round u_round (
    .i_mag      (mag),
    .i_exp0     (e0),
    .i_sign     (msgn),
    .i_single   (i_single),
    .i_rmode    (rmode),
    .o_res      (r_res),
    .o_frac_rnd (r_frnd),
    .o_frac_inx (r_finx),
    .o_ovf      (r_ovf),
    .o_unf      (r_unf),
    .o_denorm   (r_den)
  );

  // ********************************
  // special operands and result select
  // ********************************
  reg        any_nan;
  reg        any_snan;
  reg        imz;
  reg        prod_inf;
  reg        isi;
  reg        invalid;
  reg        gen;
  reg [63:0] nan_src;
  reg [63:0] res;
  reg [31:0] fs;
  reg [31:0] nf;
  reg        trap;
  reg        fresh;
  reg [4:0]  cls;
  reg [3:0]  cond;

  always @* begin
    any_nan  = nan[0] | nan[2] | (has_b & nan[1]);
    any_snan = snan[0] | snan[2] | (has_b & snan[1]);
    imz      = (inf[0] & zro[2]) | (zro[0] & inf[2]);
    prod_inf = (inf[0] | inf[2]) & !imz & !any_nan;
    isi      = has_b & prod_inf & inf[1] & (sp != sbe);
    invalid  = any_snan | imz | isi;
    gen      = 1'b0;
    // earliest NaN operand wins when several are NaN
    nan_src  = nan[0] ? i_operand_a_reg : ((has_b & nan[1]) ? i_operand_b_reg : i_operand_c_reg);
    nan_src[`FPM_QUIET_BIT] = 1'b1;
    // single target cannot hold the low payload bits
    if (i_single)
      nan_src = nan_src & `FPM_S_NAN_MASK;
    case (i_op)
      `FPM_OP_MOVE: res = i_operand_b_reg;
      `FPM_OP_NEG:  res = {~i_operand_b_reg[63], i_operand_b_reg[62:0]};
      `FPM_OP_NABS: res = {1'b1, i_operand_b_reg[62:0]};
      default: begin
        if (any_nan)
          res = nan_src;
        else if (imz | isi)
          res = `FPM_QNAN;
        else if (prod_inf)
          res = {sp ^ neg, `FPM_INF};
        else if (has_b & inf[1])
          res = {sbe ^ neg, `FPM_INF};
        else begin
          gen = 1'b1;
          res = {r_res[63] ^ neg, r_res[62:0]};
        end
      end
    endcase

    // ********************************
    // status word update
    // ********************************
    fs   = i_float_status_control;
    nf   = fs;
    // a trapped invalid keeps the old class for the handler to inspect
    trap = is_arith & invalid & fs[`FPM_B_INV_EN];
    cls  = class_of(res, gen & r_den);
    if (trap) begin
      nf[`FPM_B_FRND] = 1'b0;
      nf[`FPM_B_FINX] = 1'b0;
    end else begin
      nf[`FPM_B_FRND] = gen & r_frnd;
      nf[`FPM_B_FINX] = gen & r_finx;
      nf[`FPM_CLS_HI:`FPM_CLS_LO] = cls;
      nf[`FPM_B_OVF] = fs[`FPM_B_OVF] | (gen & r_ovf);
      nf[`FPM_B_UNF] = fs[`FPM_B_UNF] | (gen & r_unf);
      nf[`FPM_B_INX] = fs[`FPM_B_INX] | (gen & r_finx);
    end
    // invalid causes stay sticky even when the trap is taken
    nf[`FPM_B_SNAN] = fs[`FPM_B_SNAN] | any_snan;
    nf[`FPM_B_ISI]  = fs[`FPM_B_ISI] | isi;
    nf[`FPM_B_IMZ]  = fs[`FPM_B_IMZ] | imz;

    // ********************************
    // summary bits
    // ********************************
    nf[`FPM_B_INV_SUM] = |(nf & `FPM_INV_MASK);
    nf[`FPM_B_EEXC_SUM] = (nf[`FPM_B_INV_SUM] & nf[`FPM_B_INV_EN]) |
                          (nf[`FPM_B_OVF] & nf[`FPM_B_OVF_EN]) |
                          (nf[`FPM_B_UNF] & nf[`FPM_B_UNF_EN]) |
                          (nf[`FPM_B_ZDIV] & nf[`FPM_B_ZDIV_EN]) |
                          (nf[`FPM_B_INX] & nf[`FPM_B_INX_EN]);
    fresh = |(~fs & nf & `FPM_EXC_MASK);
    // summary only rises on a fresh 0 to 1 exception transition
    nf[`FPM_B_EXC_SUM] = fs[`FPM_B_EXC_SUM] | fresh;
    if (!is_arith)
      nf = fs;

    // ********************************
    // condition field image
    // ********************************
    // taken from the final word, so a move copies the incoming summaries
    cond = {nf[`FPM_B_EXC_SUM], nf[`FPM_B_EEXC_SUM],
            nf[`FPM_B_INV_SUM], nf[`FPM_B_OVF]};
  end

  // ********************************
  // result registers
  // ********************************
  // whole datapath settles in one cycle; slow but keeps issue simple
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_done                 <= 1'b0;
      o_dest_float_reg       <= 64'h0000_0000_0000_0000;
      o_dest_we              <= 1'b0;
      o_float_status_control <= 32'h0000_0000;
      o_status_we            <= 1'b0;
      o_cond_field_one       <= 4'h0;
      o_cond_we              <= 1'b0;
    end else begin
      o_done      <= i_issue;
      // a trapped invalid leaves the destination register as it was
      o_dest_we   <= i_issue & !trap;
      o_status_we <= i_issue & is_arith;
      o_cond_we   <= i_issue & i_record_bit;
      if (i_issue) begin
        o_dest_float_reg       <= res;
        o_float_status_control <= nf;
        o_cond_field_one       <= cond;
      end
    end
  end
endmodule // fpm_datapath

// ==== hdl/fpm_round.v ====
// normalizer, rounder and packer to double or single target
`timescale 1ns/1ns
`include "fpm_defines.vh"
module fpm_round (
  input  wire [168:0]       i_mag,
  input  wire signed [13:0] i_exp0,
  input  wire               i_sign,
  input  wire               i_single,
  input  wire [1:0]         i_rmode,
  output reg  [63:0]        o_res,
  output reg                o_frac_rnd,
  output reg                o_frac_inx,
  output reg                o_ovf,
  output reg                o_unf,
  output reg                o_denorm
);
  function [7:0] lzc;
    input [168:0] v;
    integer j;
    begin
      lzc = 8'ha9;
      for (j = 0; j < 169; j = j + 1) begin
        if (v[j])
          lzc = 8'ha8 - j[7:0];
      end
    end
  endfunction

  reg        [7:0]   lz;
  reg        [7:0]   lz2;
  reg        [7:0]   lsb;
  reg signed [13:0]  e_top;
  reg signed [13:0]  e_min;
  reg signed [13:0]  sh;
  reg signed [13:0]  e_res;
  reg signed [13:0]  e_bia;
  reg        [168:0] nrm;
  reg        [168:0] kept_g;
  reg        [168:0] rw;
  reg        [53:0]  rnd;
  reg                dst;
  reg                guard;
  reg                sticky;
  reg                inc;
  reg                tiny;
  reg                to_inf;

  always @* begin
    lz    = lzc(i_mag);
    nrm   = i_mag << lz;
    e_top = i_exp0 + $signed({6'h00, 8'ha8 - lz});
    e_min = i_single ? `FPM_S_EMIN : `FPM_D_EMIN;
    tiny  = (e_top < e_min) && (i_mag != 169'h0);
    sh    = e_min - e_top;
    dst   = 1'b0;
    if (tiny) begin
      if (sh > 14'sh00a8) begin
        dst = |nrm;
        nrm = 169'h0;
      end else begin
        dst = ((nrm >> sh[7:0]) << sh[7:0]) != nrm;
        nrm = nrm >> sh[7:0];
      end
      e_top = e_min;
    end
    lsb    = i_single ? `FPM_S_LSB : `FPM_D_LSB;
    kept_g = nrm >> (lsb - 8'h01);
    guard  = kept_g[0];
    sticky = dst | ((kept_g << (lsb - 8'h01)) != nrm);
    case (i_rmode)
      `FPM_RM_NEAR: inc = guard & (sticky | kept_g[1]);
      `FPM_RM_ZERO: inc = 1'b0;
      `FPM_RM_PINF: inc = !i_sign & (guard | sticky);
      default:      inc = i_sign & (guard | sticky);
    endcase
    rnd   = {1'b0, kept_g[53:1]} + {53'h0, inc};
    lz2   = lzc({rnd, 115'h0});
    e_res = e_top - (i_single ? `FPM_S_TOP : `FPM_D_TOP) + $signed({6'h00, 8'h35 - lz2});
    e_bia = e_res + `FPM_D_BIAS;
    rw    = {rnd, 115'h0} << lz2;
    o_ovf = (rnd != 54'h0) && (e_res > (i_single ? `FPM_S_EMAX : `FPM_D_EMAX));
    to_inf = (i_rmode == `FPM_RM_NEAR) || (i_rmode == `FPM_RM_PINF && !i_sign) ||
             (i_rmode == `FPM_RM_MINF && i_sign);
    o_denorm = (rnd != 54'h0) && (e_res < e_min);
    if (rnd == 54'h0)
      o_res = {i_sign, 63'h0};
    else if (o_ovf)
      o_res = {i_sign, to_inf ? `FPM_INF : (i_single ? `FPM_S_MAXF : `FPM_D_MAXF)};
    else if (!i_single && e_res < `FPM_D_EMIN)
      o_res = {i_sign, 11'h000, rnd[51:0]};
    else
      o_res = {i_sign, e_bia[10:0], rw[167:116]};
    o_frac_rnd = inc & !o_ovf;
    o_frac_inx = guard | sticky | o_ovf;
    // tininess is judged before rounding
    o_unf = tiny & (guard | sticky);
  end
endmodule // fpm_round

// ==== hdl/fpm_unpack.v ====
// operand unpacker with denormal prenormalization
`timescale 1ns/1ns
`include "fpm_defines.vh"
module fpm_unpack (
  input  wire [63:0]        i_val,
  output reg                o_sign,
  output reg signed [13:0]  o_exp,
  output reg  [52:0]        o_sig,
  output reg                o_zero,
  output reg                o_inf,
  output reg                o_nan,
  output reg                o_snan
);
  reg     [5:0] lz;
  integer       k;

  always @* begin
    o_sign = i_val[63];
    o_zero = (i_val[62:0] == 63'h0);
    o_inf  = (i_val[62:52] == 11'h7ff) && (i_val[51:0] == 52'h0);
    o_nan  = (i_val[62:52] == 11'h7ff) && (i_val[51:0] != 52'h0);
    o_snan = o_nan && !i_val[`FPM_QUIET_BIT];
    lz = 6'h00;
    for (k = 0; k < 52; k = k + 1) begin
      if (i_val[k])
        lz = 6'h34 - k[5:0];
    end
    if (o_zero) begin
      // fixed at -1800, yet a zero factor can still push a small addend down to the sticky bit
      o_exp = `FPM_ZERO_EXP;
      o_sig = 53'h0;
    end else if (i_val[62:52] == 11'h000) begin
      o_exp = `FPM_D_EMIN - $signed({8'h00, lz});
      o_sig = {1'b0, i_val[51:0]} << lz;
    end else begin
      o_exp = $signed({3'h0, i_val[62:52]}) - `FPM_D_BIAS;
      o_sig = {1'b1, i_val[51:0]};
    end
  end
endmodule // fpm_unpack

// ==== include/fpm_defines.vh ====
// shared constants of the multiply and fused multiply datapath
`ifndef FPM_DEFINES_VH
`define FPM_DEFINES_VH
// ********************************
// opcodes and rounding modes
// ********************************
`define FPM_OP_MOVE    3'h0
`define FPM_OP_NEG     3'h1
`define FPM_OP_NABS    3'h2
`define FPM_OP_MUL     3'h3
`define FPM_OP_MSUB    3'h4
`define FPM_OP_NMADD   3'h5
`define FPM_RM_NEAR    2'h0
`define FPM_RM_ZERO    2'h1
`define FPM_RM_PINF    2'h2
`define FPM_RM_MINF    2'h3
// ********************************
// status word bit positions
// ********************************
`define FPM_B_EXC_SUM  31
`define FPM_B_EEXC_SUM 30
`define FPM_B_INV_SUM  29
`define FPM_B_OVF      28
`define FPM_B_UNF      27
`define FPM_B_ZDIV     26
`define FPM_B_INX      25
`define FPM_B_SNAN     24
`define FPM_B_ISI      23
`define FPM_B_IMZ      20
`define FPM_B_FRND     18
`define FPM_B_FINX     17
`define FPM_CLS_HI     16
`define FPM_CLS_LO     12
`define FPM_B_INV_EN   7
`define FPM_B_OVF_EN   6
`define FPM_B_UNF_EN   5
`define FPM_B_ZDIV_EN  4
`define FPM_B_INX_EN   3
`define FPM_RMODE_HI   1
`define FPM_RMODE_LO   0
`define FPM_EXC_MASK   32'h1ff8_0700
`define FPM_INV_MASK   32'h01f8_0700
// ********************************
// result class codes
// ********************************
`define FPM_C_QNAN     5'h11
`define FPM_C_NINF     5'h09
`define FPM_C_NNORM    5'h08
`define FPM_C_NDEN     5'h18
`define FPM_C_NZERO    5'h12
`define FPM_C_PZERO    5'h02
`define FPM_C_PDEN     5'h14
`define FPM_C_PNORM    5'h04
`define FPM_C_PINF     5'h05
// ********************************
// exponent ranges and encodings
// ********************************
`define FPM_D_BIAS     14'sh03ff
`define FPM_D_EMIN     (-14'sh03fe)
`define FPM_D_EMAX     14'sh03ff
`define FPM_S_EMIN     (-14'sh007e)
`define FPM_S_EMAX     14'sh007f
`define FPM_ZERO_EXP   (-14'sh0708)
`define FPM_D_LSB      8'h74
`define FPM_S_LSB      8'h91
`define FPM_D_TOP      14'sh0034
`define FPM_S_TOP      14'sh0017
`define FPM_FAR_ADD    14'sh003d
`define FPM_QNAN       64'h7ff8_0000_0000_0000
`define FPM_INF        63'h7ff0_0000_0000_0000
`define FPM_D_MAXF     63'h7fef_ffff_ffff_ffff
`define FPM_S_MAXF     63'h47ef_ffff_e000_0000
`define FPM_S_NAN_MASK 64'hffff_ffff_e000_0000
`define FPM_QUIET_BIT  51
`endif
